// >>> dv/gmrs_phy_model.sv
// gmrs_phy_model: behavioural gigabit phy facing the sublayer
`timescale 1ns/1ps
`default_nettype none

module gmrs_phy_model (
  // transmit pins from the sublayer
  input  wire logic       gtx_clk,
  input  wire logic [7:0] gmii_txd,
  input  wire logic       gmii_tx_en,
  input  wire logic       gmii_tx_er,
  // receive pins toward the sublayer
  output logic            rx_clk,
  output logic      [7:0] gmii_rxd,
  output logic            gmii_rx_dv,
  output logic            gmii_rx_er,
  // media status levels
  output logic            gmii_crs,
  output logic            gmii_col
);
  int bad_code = 0; // reserved extension codes seen

  // sample on rise, flag reserved codes
  always @(posedge gtx_clk) begin
    if (!gmii_tx_en && gmii_tx_er && gmii_txd != 8'h0f && gmii_txd != 8'h1f) begin
      bad_code++;
    end
  end

  // rx clock runs free, phase unrelated to the system clock
  initial begin
    rx_clk = 1'b0;
    #37;
    forever #80 rx_clk = ~rx_clk;
  end

  // quiet pins at start
  initial begin
    gmii_rxd   = 8'h00;
    gmii_rx_dv = 1'b0;
    gmii_rx_er = 1'b0;
    gmii_crs   = 1'b0;
    gmii_col   = 1'b0;
  end

  // one octet per rx clock, changed off the sampling edge
  task automatic send(input logic dv, input logic er, input logic [7:0] d);
    @(negedge rx_clk);
    gmii_rx_dv = dv;
    gmii_rx_er = er;
    gmii_rxd   = d;
  endtask : send

  // released data lines show the inverse of the last octet
  task automatic idle();
    @(negedge rx_clk);
    gmii_rx_dv = 1'b0;
    gmii_rx_er = 1'b0;
    gmii_rxd   = ~gmii_rxd;
  endtask : idle

  // carrier and collision are plain levels
  task automatic media(input logic c, input logic k);
    gmii_crs = c;
    gmii_col = k;
  endtask : media
endmodule : gmrs_phy_model

`default_nettype wire

// >>> dv/tb.sv
// tb: self-checking bench for the gmii reconciliation map
`timescale 1ns/1ps
`default_nettype none

module tb;
  // reset length in clocks; the rx side is cleared asynchronously
  localparam int RST_CYC = 10;
  typedef struct packed {
    logic v; logic [1:0] u; logic [7:0] d; logic e; logic [7:0] xd; logic xen; logic xer;
  } gmrs_row_t;
  logic       clk, rst_b, tx_req_valid, tx_req_err, gtx_clk, gmii_tx_en, gmii_tx_er;
  logic [1:0] tx_req_unit, rx_ind_unit;
  logic [7:0] tx_req_data, gmii_txd, gmii_rxd;
  logic       rx_clk, gmii_rx_dv, gmii_rx_er, gmii_crs, gmii_col;
  logic       rx_ind_valid, rx_frame_err, carrier_on, carrier_ind, sig_err, sig_ind;
  logic [2:0] rxq[$];        // delivered bits: {frame error, unit}
  int         errors, cmp_count, n_car, n_sig;
  logic [1:0] st [4] = '{2'b10, 2'b11, 2'b01, 2'b00}; // {crs, col} steps
  // unit codes: 0 data, 1 extend, 2 extend error, 3 complete
  gmrs_row_t  rows [10] = '{
    '{1'b1, 2'h0, 8'h55, 1'b0, 8'h55, 1'b1, 1'b0},
    '{1'b1, 2'h0, 8'ha3, 1'b1, 8'ha3, 1'b1, 1'b1},
    '{1'b1, 2'h1, 8'h00, 1'b0, gmrs_pkg::EXT_CODE, 1'b0, 1'b1},
    '{1'b1, 2'h1, 8'h00, 1'b1, gmrs_pkg::EXT_ERR_CODE, 1'b0, 1'b1},
    '{1'b1, 2'h2, 8'h00, 1'b0, gmrs_pkg::EXT_ERR_CODE, 1'b0, 1'b1},
    '{1'b1, 2'h0, 8'h3c, 1'b0, 8'h3c, 1'b1, 1'b0},
    '{1'b1, 2'h3, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{1'b1, 2'h1, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{1'b1, 2'h0, 8'h81, 1'b0, 8'h81, 1'b1, 1'b0},
    '{1'b0, 2'h0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0}};

  gmrs_core dut_u (.clk, .rst_b, .tx_req_valid, .tx_req_unit, .tx_req_data, .tx_req_err,
    .gtx_clk, .gmii_txd, .gmii_tx_en, .gmii_tx_er, .rx_clk, .gmii_rxd, .gmii_rx_dv,
    .gmii_rx_er, .gmii_crs, .gmii_col, .rx_ind_valid, .rx_ind_unit, .rx_frame_err,
    .carrier_on, .carrier_ind, .sig_err, .sig_ind);
  gmrs_phy_model phy_u (.gtx_clk, .gmii_txd, .gmii_tx_en, .gmii_tx_er, .rx_clk, .gmii_rxd,
    .gmii_rx_dv, .gmii_rx_er, .gmii_crs, .gmii_col);

  // system clock, 10 ns
  always #5 clk = ~clk;

  // collect at the fall, outputs settle after the rise
  always @(negedge clk) begin
    if (rx_ind_valid === 1'b1) rxq.push_back({rx_frame_err, rx_ind_unit});
    if (carrier_ind === 1'b1) n_car++;
    if (sig_ind === 1'b1) n_sig++;
  end

  // transmit pins, gtx_clk high at a system clock fall
  task automatic chk_tx(input logic [7:0] d, input logic en, input logic er);
    // gtx_clk flips with clk, so look 1 ns after the fall
    #1;
    cmp_count++;
    if ({gtx_clk, gmii_txd, gmii_tx_en, gmii_tx_er} !== {1'b1, d, en, er}) begin
      errors++;
      $display("wrong value at %0t: tx %h %b %b", $time, gmii_txd, gmii_tx_en, gmii_tx_er);
    end
  endtask : chk_tx

  // small vectors of design outputs
  task automatic chk_v(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk_v

  // counts kept by the bench
  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      errors++;
      $display("wrong value at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask : chk_n

  // expected bit indication, lsb first
  function automatic logic [2:0] bitv(input logic e, input logic [7:0] d, input int b);
    return {e, 1'b0, d[b]};
  endfunction : bitv

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // watchdog, runs are a few microseconds
  initial begin
    #50us;
    errors++;
    final_report();
  end

  initial begin
    {clk, rst_b, tx_req_valid, tx_req_unit, tx_req_data, tx_req_err} = '0;
    repeat (RST_CYC) @(negedge clk);
    rst_b = 1'b1;
    chk_tx(8'h00, 1'b0, 1'b0);
    // one request per cycle, answer one cycle later
    for (int i = 0; i < 10; i++) begin
      {tx_req_valid, tx_req_unit, tx_req_data, tx_req_err} = rows[i][21:10];
      @(negedge clk);
      chk_tx(rows[i].xd, rows[i].xen, rows[i].xer);
    end
    $display("test tx done");
    // stray extension ignored, clean frame, then errored frame
    phy_u.send(1'b0, 1'b1, 8'h0f);
    phy_u.idle();
    phy_u.send(1'b1, 1'b0, 8'ha5);
    phy_u.send(1'b0, 1'b1, 8'h0f);
    phy_u.idle();
    phy_u.send(1'b1, 1'b0, 8'h11);
    phy_u.send(1'b1, 1'b1, 8'h22);
    phy_u.send(1'b1, 1'b0, 8'h33);
    phy_u.send(1'b0, 1'b1, 8'h1f);
    phy_u.idle();
    repeat (80) @(negedge clk);
    chk_n(rxq.size(), 48);
    for (int b = 0; b < 8; b++) begin
      chk_v(rxq[b], bitv(1'b0, 8'ha5, b));
      chk_v(rxq[8 + b], 3'b010);
      chk_v(rxq[16 + b], bitv(1'b0, 8'h11, b));
      chk_v(rxq[24 + b], bitv(1'b1, 8'hdd, b));
      chk_v(rxq[32 + b], bitv(1'b1, 8'hcc, b));
      chk_v(rxq[40 + b], bitv(1'b1, 8'he0, b));
    end
    $display("test rx done");
    // carrier and collision steps, one pulse per change
    for (int k = 0; k < 4; k++) begin
      phy_u.media(st[k][1], st[k][0]);
      repeat (6) @(negedge clk);
      chk_v({1'b0, carrier_on, sig_err}, {1'b0, st[k]});
    end
    chk_n(n_car, 2);
    chk_n(n_sig, 2);
    $display("test status done");
    // reset in mid frame clears the pins at once
    {tx_req_valid, tx_req_unit, tx_req_data} = {1'b1, 2'h0, 8'h77};
    @(negedge clk);
    chk_tx(8'h77, 1'b1, 1'b0);
    rst_b = 1'b0;
    @(negedge clk);
    chk_tx(8'h00, 1'b0, 1'b0);
    chk_v({carrier_on, sig_err, rx_ind_valid}, 3'b000);
    tx_req_valid = 1'b0;
    repeat (RST_CYC) @(negedge clk);
    rst_b = 1'b1;
    // first request right after release is taken
    {tx_req_valid, tx_req_unit, tx_req_data} = {1'b1, 2'h0, 8'h5a};
    @(negedge clk);
    chk_tx(8'h5a, 1'b1, 1'b0);
    tx_req_valid = 1'b0;
    chk_n(phy_u.bad_code, 0);
    $display("test reset done");
    final_report();
  end
endmodule : tb

`default_nettype wire

// >>> rtl/gmrs_core.sv
// gmrs_core: gmii reconciliation sublayer, transmit encode and receive decode
//
// What this block does
// R01 - tx_en high carries one data octet
// R02 - extension: tx_en low, tx_er high, code
// R03 - transmit complete drops tx_en and tx_er
// R04 - source gtx_clk, one update per group
// R05 - rx_dv high: each rxd line data
// R06 - rx_dv low, rx_er, code: extend
// R07 - eight bit indications per octet
// R08 - carrier level follows crs
// R09 - carrier indication on each crs change
// R10 - signal error level follows col
// R11 - signal indication on each col change
// R12 - rx_dv with rx_er forces check error
// R13 - extend error delivers data, check error
// R14 - substitute data so crc fails
// R15 - frame corruption asserts tx_er with tx_en
// R16 - extension corruption sends extend error code
// R17 - repeater may propagate rx_er to tx_er
// R18 - 0f extend, 1f extend error codes
// R19 - gtx_clk continuous, phy samples rising
// R20 - tx_en spans frame, drops after last
// R21 - sample receive pins on rx_clk rise
// R22 - idle: tx_en and tx_er both low
`timescale 1ns/1ps
`default_nettype none

module gmrs_core (
  // system clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // mac transmit requests, one per group of eight bits
  input  wire logic       tx_req_valid,
  input  wire logic [1:0] tx_req_unit,
  input  wire logic [7:0] tx_req_data,
  input  wire logic       tx_req_err,
  // gmii transmit
  output logic            gtx_clk,
  output logic      [7:0] gmii_txd,
  output logic            gmii_tx_en,
  output logic            gmii_tx_er,
  // gmii receive, on the phy clock
  input  wire logic       rx_clk,
  input  wire logic [7:0] gmii_rxd,
  input  wire logic       gmii_rx_dv,
  input  wire logic       gmii_rx_er,
  // gmii media status, asynchronous
  input  wire logic       gmii_crs,
  input  wire logic       gmii_col,
  // mac receive bit indications
  output logic            rx_ind_valid,
  output logic      [1:0] rx_ind_unit,
  output logic            rx_frame_err,
  // mac status indications
  output logic            carrier_on,
  output logic            carrier_ind,
  output logic            sig_err,
  output logic            sig_ind
);

  // true when an octet with rx_dv low and rx_er high carries the code
  function automatic logic ext_hit(input logic dv, input logic er,
                                   input logic [7:0] d, input logic [7:0] code);
    ext_hit = !dv && er && (d == code);
  endfunction : ext_hit

  // transmit encode, on clk
  gmrs_pkg::gmrs_tx_state_t tx_state_q;   // framing state
  gmrs_pkg::gmrs_tx_state_t tx_state_d;
  logic [7:0]               txd_q;        // registered octet
  logic [7:0]               txd_d;
  logic                     tx_en_q;      // registered enable
  logic                     tx_en_d;
  logic                     tx_er_q;      // registered error
  logic                     tx_er_d;

  // R04 forwarded clock
  // R19 inverted so octets change mid-cycle and are stable at the rise
  assign gtx_clk = ~clk;

  // encode one request into the next octet and framing state
  always_comb begin
    tx_state_d = gmrs_pkg::TX_IDLE;
    txd_d      = gmrs_pkg::TXD_IDLE;
    tx_en_d    = 1'b0;
    tx_er_d    = 1'b0;
    if (tx_req_valid) begin
      unique case (tx_req_unit)
        // R01 data octet under tx_en
        gmrs_pkg::TXU_DATA: begin
          tx_state_d = gmrs_pkg::TX_DATA;
          txd_d      = tx_req_data;
          tx_en_d    = 1'b1;
          // R15 corrupt frame: tx_er with tx_en
          // R17 repeater feeds its rx error in here
          tx_er_d    = tx_req_err;
        end
        // R02 extension follows data or extension only
        gmrs_pkg::TXU_EXTEND, gmrs_pkg::TXU_EXT_ERR: begin
          if (tx_state_q != gmrs_pkg::TX_IDLE) begin
            tx_state_d = gmrs_pkg::TX_EXT;
            // R16 R18 corrupted extension sends 1f, else 0f
            txd_d      = (tx_req_err || tx_req_unit == gmrs_pkg::TXU_EXT_ERR) ?
                         gmrs_pkg::EXT_ERR_CODE : gmrs_pkg::EXT_CODE;
            tx_er_d    = 1'b1;
          end
        end
        // R03 complete: both drop, idle defaults hold
        gmrs_pkg::TXU_COMPLETE: begin
          tx_state_d = gmrs_pkg::TX_IDLE;
        end
      endcase
    end
    // R22 no request leaves tx_en and tx_er low
  end

  // R04 one octet update per request, framing state with it
  // R20 tx_en falls on the edge after the last octet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_q <= gmrs_pkg::TX_IDLE;
      txd_q      <= gmrs_pkg::TXD_IDLE;
      tx_en_q    <= 1'b0;
      tx_er_q    <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      txd_q      <= txd_d;
      tx_en_q    <= tx_en_d;
      tx_er_q    <= tx_er_d;
    end
  end

  assign gmii_txd   = txd_q;
  assign gmii_tx_en = tx_en_q;
  assign gmii_tx_er = tx_er_q;
  a_tx_data_map: assert property ( // R01
    @(posedge clk) disable iff (!rst_b)
    tx_req_valid && tx_req_unit == gmrs_pkg::TXU_DATA
    |=> gmii_tx_en && gmii_txd == $past(tx_req_data) && gmii_tx_er == $past(tx_req_err))
    else $error("data octet not mapped");
  a_tx_ext_code: assert property ( // R02
    @(posedge clk) disable iff (!rst_b)
    tx_req_valid && tx_req_unit == gmrs_pkg::TXU_EXTEND && !tx_req_err
    && tx_state_q != gmrs_pkg::TX_IDLE
    |=> !gmii_tx_en && gmii_tx_er && gmii_txd == 8'h0f)
    else $error("extend not encoded");
  a_tx_ext_err: assert property ( // R16
    @(posedge clk) disable iff (!rst_b)
    tx_req_valid && tx_req_unit == gmrs_pkg::TXU_EXT_ERR && tx_state_q != gmrs_pkg::TX_IDLE
    |=> !gmii_tx_en && gmii_tx_er && gmii_txd == 8'h1f)
    else $error("extend error not encoded");
  a_tx_complete: assert property ( // R03
    @(posedge clk) disable iff (!rst_b)
    gmii_tx_en && tx_req_valid && tx_req_unit == gmrs_pkg::TXU_COMPLETE
    |=> !gmii_tx_en && !gmii_tx_er)
    else $error("complete did not drop enables");
  a_tx_idle_quiet: assert property ( // R22
    @(posedge clk) disable iff (!rst_b)
    !tx_req_valid [*2] |=> !gmii_tx_en && !gmii_tx_er && $stable(gmii_txd))
    else $error("idle line not quiet");

  // receive, on rx_clk
  logic [1:0] rx_rst_q;     // reset release synchroniser for rx_clk
  logic [7:0] rxd_q;        // sampled octet
  logic       rx_dv_q;      // sampled data valid
  logic       rx_er_q;      // sampled error
  logic       rx_act_q;     // frame or its extension in progress
  logic       err_seen_q;   // error seen in the current frame
  logic       err_now;      // error on the current octet
  logic       ext_ok;       // valid extend octet
  logic       ext_bad;      // extend error octet
  logic [1:0] unit_now;     // 00 none, 01 data, 10 extend
  logic       xfer_tgl_q;   // toggles once per octet handed over
  logic [9:0] xfer_word_q;  // {extend, bad, data}, held until next octet

  // async assert, release on rx_clk
  always_ff @(posedge rx_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_rst_q <= 2'b00;
    end else begin
      rx_rst_q <= {rx_rst_q[0], 1'b1};
    end
  end

  // R21 sample receive pins on rx_clk rise
  always_ff @(posedge rx_clk or negedge rx_rst_q[1]) begin
    if (!rx_rst_q[1]) begin
      rxd_q   <= 8'h00;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
    end else begin
      rxd_q   <= gmii_rxd;
      rx_dv_q <= gmii_rx_dv;
      rx_er_q <= gmii_rx_er;
    end
  end

  // R06 extend decode only inside a frame's tail
  assign ext_ok  = rx_act_q && ext_hit(rx_dv_q, rx_er_q, rxd_q, gmrs_pkg::EXT_CODE);
  assign ext_bad = rx_act_q && ext_hit(rx_dv_q, rx_er_q, rxd_q, gmrs_pkg::EXT_ERR_CODE);
  // R12 rx_dv with rx_er; R13 extend error
  assign err_now = (rx_dv_q && rx_er_q) || ext_bad;

  // R05 data under rx_dv; R13 extend error also delivered as data
  always_comb begin
    unit_now = 2'b00;
    if (rx_dv_q || ext_bad) begin
      unit_now = 2'b01;
    end else if (ext_ok) begin
      unit_now = 2'b10;
    end
  end

  // frame activity and sticky error, cleared when the line goes idle
  always_ff @(posedge rx_clk or negedge rx_rst_q[1]) begin
    if (!rx_rst_q[1]) begin
      rx_act_q   <= 1'b0;
      err_seen_q <= 1'b0;
    end else begin
      rx_act_q   <= rx_dv_q || ext_ok || ext_bad;
      // R12 error sticks to the end of frame; a set beats the idle clear
      err_seen_q <= err_now || (err_seen_q && (rx_dv_q || rx_er_q));
    end
  end

  // hand each octet over by toggle; the word is held a whole rx_clk period
  always_ff @(posedge rx_clk or negedge rx_rst_q[1]) begin
    if (!rx_rst_q[1]) begin
      xfer_tgl_q  <= 1'b0;
      xfer_word_q <= 10'h000;
    end else if (unit_now != 2'b00) begin
      xfer_tgl_q     <= ~xfer_tgl_q;
      xfer_word_q[9] <= unit_now[1];
      xfer_word_q[8] <= err_now || err_seen_q;
      // R14 inverted octets make the crc fail on top of the error flag
      xfer_word_q[7:0] <= (err_now || err_seen_q) ? ~rxd_q : rxd_q;
    end
  end
  a_rx_err_mark: assert property ( // R12
    @(posedge rx_clk) disable iff (!rx_rst_q[1])
    rx_dv_q && rx_er_q |=> err_seen_q && xfer_word_q[8])
    else $error("receive error not marked");

  // receive, handed over to clk
  logic [2:0] tgl_s_q;     // toggle synchroniser, bit 2 is history
  logic       new_word;    // one octet arrived
  logic [3:0] ser_cnt_q;   // bits left to deliver
  logic [7:0] ser_sh_q;    // octet being shifted out, lsb first
  logic       ser_ext_q;   // octet is an extension
  logic       ser_bad_q;   // octet carries a check error
  logic       ind_valid_q; // registered indication strobe
  logic [1:0] ind_unit_q;  // registered indication value
  logic       frame_err_q; // registered check error

  // only bits 1 and 2 are read; bit 0 is the raw first stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_s_q <= 3'h0;
    end else begin
      tgl_s_q <= {tgl_s_q[1:0], xfer_tgl_q};
    end
  end

  assign new_word = tgl_s_q[2] ^ tgl_s_q[1];

  // loader; eight clk cycles fit well inside one rx_clk octet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_cnt_q <= 4'h0;
      ser_sh_q  <= 8'h00;
      ser_ext_q <= 1'b0;
      ser_bad_q <= 1'b0;
    end else if (new_word) begin
      // R07 eight indications per octet
      ser_cnt_q <= gmrs_pkg::BITS_PER_OCTET;
      ser_sh_q  <= xfer_word_q[7:0];
      ser_ext_q <= xfer_word_q[9];
      ser_bad_q <= xfer_word_q[8];
    end else if (ser_cnt_q != 4'h0) begin
      ser_cnt_q <= ser_cnt_q - 4'h1;
      ser_sh_q  <= {1'b0, ser_sh_q[7:1]};
    end
  end

  // registered bit indications
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ind_valid_q <= 1'b0;
      ind_unit_q  <= gmrs_pkg::BIT_ZERO;
      frame_err_q <= 1'b0;
    end else begin
      ind_valid_q <= (ser_cnt_q != 4'h0) && !new_word;
      // R06 extend octets give eight extend bits
      if (ser_ext_q) begin
        ind_unit_q <= gmrs_pkg::BIT_EXTEND;
      end else begin
        ind_unit_q <= ser_sh_q[0] ? gmrs_pkg::BIT_ONE : gmrs_pkg::BIT_ZERO;
      end
      // R12 check error shown with every bit of a bad octet
      frame_err_q <= ser_bad_q && (ser_cnt_q != 4'h0);
    end
  end

  assign rx_ind_valid = ind_valid_q;
  assign rx_ind_unit  = ind_unit_q;
  assign rx_frame_err = frame_err_q;
  a_rx_eight_bits: assert property ( // R07
    @(posedge clk) disable iff (!rst_b)
    new_word |-> ##2 rx_ind_valid [*8] ##1 !rx_ind_valid)
    else $error("octet not eight indications");

  // media status, on clk
  logic [1:0] crs_s_q;     // crs synchroniser
  logic [1:0] col_s_q;     // col synchroniser
  logic       car_q;       // carrier level
  logic       car_ind_q;   // carrier change pulse
  logic       serr_q;      // signal error level
  logic       serr_ind_q;  // signal change pulse

  // pins are asynchronous, two stages each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crs_s_q <= 2'b00;
      col_s_q <= 2'b00;
    end else begin
      crs_s_q <= {crs_s_q[0], gmii_crs};
      col_s_q <= {col_s_q[0], gmii_col};
    end
  end

  // R08 carrier level; R09 pulse on every change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      car_q     <= gmrs_pkg::CARRIER_RST;
      car_ind_q <= 1'b0;
    end else begin
      car_q     <= crs_s_q[1];
      car_ind_q <= crs_s_q[1] ^ car_q;
    end
  end

  // R10 signal error level; R11 pulse on every change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serr_q     <= gmrs_pkg::SIGERR_RST;
      serr_ind_q <= 1'b0;
    end else begin
      serr_q     <= col_s_q[1];
      serr_ind_q <= col_s_q[1] ^ serr_q;
    end
  end

  assign carrier_on  = car_q;
  assign carrier_ind = car_ind_q;
  assign sig_err     = serr_q;
  assign sig_ind     = serr_ind_q;
  a_carrier_ind: assert property ( // R09
    @(posedge clk) disable iff (!rst_b)
    $changed(carrier_on) |-> carrier_ind ##1 !carrier_ind || $changed(carrier_on))
    else $error("carrier change without indication");
  a_signal_ind: assert property ( // R11
    @(posedge clk) disable iff (!rst_b)
    (col_s_q[1] != sig_err) |=> sig_ind && sig_err == $past(col_s_q[1]))
    else $error("signal change without indication");

endmodule : gmrs_core

`default_nettype wire

// >>> rtl/gmrs_pkg.sv
// gmrs_pkg: shared constants and types of the gmii reconciliation map
package gmrs_pkg;

  // transmit octet codes; the two extend codes go with tx_en low and tx_er high, idle with both low
  localparam logic [7:0] EXT_CODE     = 8'h0f; // carrier extend
  localparam logic [7:0] EXT_ERR_CODE = 8'h1f; // carrier extend error
  localparam logic [7:0] TXD_IDLE     = 8'h00; // idle octet, no effect on phy

  // bit indications delivered per received octet
  localparam logic [3:0] BITS_PER_OCTET = 4'h8;

  // reset values of status outputs
  localparam logic       CARRIER_RST = 1'b0;
  localparam logic       SIGERR_RST  = 1'b0;

  // one transmit request covers a group of eight bit requests
  typedef enum logic [1:0] {
    TXU_DATA     = 2'b00, // eight one or zero bits
    TXU_EXTEND   = 2'b01, // eight extend bit equivalents
    TXU_EXT_ERR  = 2'b10, // eight extend_error bit equivalents
    TXU_COMPLETE = 2'b11  // transmit complete
  } gmrs_tx_unit_t;

  // single-bit receive indication values
  typedef enum logic [1:0] {
    BIT_ZERO   = 2'b00,
    BIT_ONE    = 2'b01,
    BIT_EXTEND = 2'b10
  } gmrs_bit_t;

  // transmit framing state
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, // between transmissions
    TX_DATA = 2'b01, // frame octets on the wire
    TX_EXT  = 2'b10  // carrier extension after data
  } gmrs_tx_state_t;

endpackage : gmrs_pkg
